// ---- sim/board_reset_driver.sv ----
// board-level driver of the shared reset pin
`timescale 1ns/100ps
module board_reset_driver (
  input wire logic hold_low,
  output logic pin
);
  // pull-up keeps a released pin high
  assign pin = hold_low ? 1'b0 : 1'b1;
endmodule // board_reset_driver

// ---- sim/tb_reset_source_controller.sv ----
// self-checking bench for the reset source controller
`timescale 1ns/100ps
module tb_reset_source_controller;
  import reset_source_pkg::*;
  localparam int W = 8;
  logic core_clk = 0, sys_rst = 1, por = 1, hold_low = 0, abn = 0;
  logic cr_wr = 0, cr_d = 0, pd_wr = 0, pd_d = 0, key_wr = 0;
  logic [4:0] fac = '0;
  logic [7:0] key_d = '0;
  logic pin, sreset, hold, wu_act, tle, ef, creq, pdis, pfun, pval;
  logic [15:0] fva;
  logic [4:0] st;
  int err_total = 0, checks = 0, wu;
  initial forever #12.5 core_clk = ~core_clk;
  board_reset_driver board_reset_driver_i (.hold_low(hold_low), .pin(pin));
  reset_source_controller #(.WARMUP_LEN(W)) reset_source_controller_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .por_below_threshold(por),
    .shared_reset_port_pin(pin), .volt_detect_event(fac[0]),
    .wdt_overflow(fac[1]), .clock_deadlock(fac[2]), .trim_corrupt(fac[3]),
    .flash_standby_access(fac[4]), .trim_load_abnormal(abn),
    .cause_clear_request_wr(cr_wr), .cause_clear_request_wdata(cr_d),
    .reset_pin_disable_wr(pd_wr), .reset_pin_disable_wdata(pd_d),
    .key_wr(key_wr), .key_wdata(key_d), .system_reset(sreset),
    .cpu_hold(hold), .warmup_active(wu_act), .trim_load_en(tle),
    .fetch_vector_addr(fva), .reset_cause_status(st),
    .trim_data_error_flag(ef), .cause_clear_request(creq),
    .reset_pin_disable(pdis), .reset_pin_function(pfun),
    .port_pin_value(pval));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run_up();
    int n;
    wu = 0;
    n = 0;
    while (hold !== 1'b0 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
      if (wu_act === 1'b1 && tle === 1'b1) wu++;
    end
    check("run up", hold, 1'b0);
  endtask
  task automatic key(input logic [7:0] v);
    key_d = v;
    key_wr = 1;
    @(negedge core_clk);
    key_wr = 0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic stage(input logic pd, input logic v);
    {cr_wr, cr_d} = {~pd, v};
    {pd_wr, pd_d} = {pd, v};
    @(negedge core_clk);
    {cr_wr, pd_wr} = 2'b00;
    @(negedge core_clk);
  endtask
  task automatic low_pin(input int n);
    hold_low = 1;
    repeat (n) @(negedge core_clk);
    hold_low = 0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic t_power_up();
    repeat (20) @(negedge core_clk);
    check("por hold", sreset, 1'b1);
    abn = 1;
    por = 0;
    run_up();
    abn = 0;
    check("warm-up len", 16'(wu), 16'(W));
    check("vector", fva, 16'hfffe);
    check("trim flag", ef, 1'b1);
    check("pin function", pfun, 1'b1);
    $display("test power_up done");
  endtask
  task automatic t_factors();
    logic [4:0] exp;
    exp = '0;
    for (int i = 0; i < 5; i++)
    begin
      fac[i] = 1;
      @(negedge core_clk);
      fac[i] = 0;
      check("factor hold", hold, 1'b1);
      run_up();
      exp[i] = 1'b1;
      check("cause status", st, exp);
      check("factor warm-up", 16'(wu), 16'(W));
    end
    check("trim flag kept", ef, 1'b1);
    $display("test factors done");
  endtask
  task automatic t_restart();
    fac[2] = 1;
    @(negedge core_clk);
    fac[2] = 0;
    repeat (2) @(negedge core_clk);
    check("restart warm", wu_act, 1'b1);
    fac[1] = 1;
    @(negedge core_clk);
    fac[1] = 0;
    check("restart reset", {sreset, wu_act, tle}, 3'b100);
    run_up();
    check("restart len", 16'(wu), 16'(W));
    check("restart status", st, 5'h1f);
    $display("test restart done");
  endtask
  task automatic t_clear();
    key(KEY_CAUSE_CLEAR);
    check("no request", st, 5'h1f);
    stage(1'b0, 1'b1);
    check("request", creq, 1'b1);
    key(8'h33);
    check("bad key", st, 5'h1f);
    key(KEY_CAUSE_CLEAR);
    check("cleared", st, 5'h00);
    check("request off", creq, 1'b0);
    $display("test clear done");
  endtask
  task automatic t_pin();
    fac[1] = 1;
    @(negedge core_clk);
    fac[1] = 0;
    run_up();
    low_pin(100);
    check("short low", sreset, 1'b0);
    hold_low = 1;
    repeat (210) @(negedge core_clk);
    check("pin reset", sreset, 1'b1);
    hold_low = 0;
    run_up();
    check("pin warm-up", 16'(wu), 16'(W));
    check("pin clears", st, 5'h00);
    stage(1'b1, 1'b1);
    key(KEY_PIN_SWITCH);
    check("disabled", {pdis, pfun}, 2'b10);
    hold_low = 1;
    repeat (210) @(negedge core_clk);
    check("port no reset", sreset, 1'b0);
    check("port value", pval, 1'b0);
    hold_low = 0;
    repeat (2) @(negedge core_clk);
    stage(1'b1, 1'b0);
    key(KEY_PIN_SWITCH);
    check("restored", {pdis, pfun}, 2'b01);
    $display("test pin done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge core_clk);
    sys_rst = 0;
    t_power_up();
    t_factors();
    t_restart();
    t_clear();
    t_pin();
    test_done();
  end
  initial
  begin
    #500000;
    err_total++;
    test_done();
  end
endmodule // tb_reset_source_controller

// ---- verilog/reset_source_controller.sv ----
// combines reset sources, runs warm-up, keeps cause status
`timescale 1ns/100ps
module reset_source_controller #(
  parameter int WARMUP_LEN = reset_source_pkg::WARMUP_CYCLES
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic por_below_threshold,
  input wire logic shared_reset_port_pin,
  input wire logic volt_detect_event,
  input wire logic wdt_overflow,
  input wire logic clock_deadlock,
  input wire logic trim_corrupt,
  input wire logic flash_standby_access,
  input wire logic trim_load_abnormal,
  input wire logic cause_clear_request_wr,
  input wire logic cause_clear_request_wdata,
  input wire logic reset_pin_disable_wr,
  input wire logic reset_pin_disable_wdata,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  output logic system_reset,
  output logic cpu_hold,
  output logic warmup_active,
  output logic trim_load_en,
  output logic [15:0] fetch_vector_addr,
  output logic [reset_source_pkg::CAUSE_BITS-1:0] reset_cause_status,
  output logic trim_data_error_flag,
  output logic cause_clear_request,
  output logic reset_pin_disable,
  output logic reset_pin_function,
  output logic port_pin_value
);
  import reset_source_pkg::*;

  typedef struct packed {
    phase_t phase;
    logic [15:0] warm_cnt;
    logic [15:0] low_cnt;
    logic pin_rst;
    logic sys_rst_out;
    logic hold;
    logic warm;
    logic [CAUSE_BITS-1:0] cause;
    logic trim_err;
    logic clr_req;
    logic pin_dis_stage;
    logic pin_dis;
    logic pin_fun;
    logic port_val;
    logic [15:0] vec;
    logic [15:0] low_run;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [CAUSE_BITS-1:0] factors;
  logic ext_reset;
  logic any_reset;

  always_comb
  begin
    factors = '0;
    factors[CAUSE_VOLT] = volt_detect_event;
    factors[CAUSE_WDT] = wdt_overflow;
    factors[CAUSE_CLK] = clock_deadlock;
    factors[CAUSE_TRIM] = trim_corrupt;
    factors[CAUSE_FLASH] = flash_standby_access;
    // a pin reset needs a qualified low level; ORed with power-on
    ext_reset = por_below_threshold || cur.pin_rst;
    any_reset = ext_reset || (|factors);
    next_cur = cur;
    // low must persist 5 us before it counts as a reset
    if (!cur.pin_dis && !shared_reset_port_pin)
    begin
      if (cur.low_cnt >= 16'(PIN_LOW_CYCLES - 1))
        next_cur.pin_rst = 1'b1;
      else
        next_cur.low_cnt = cur.low_cnt + 16'h0001;
    end
    else
    begin
      next_cur.low_cnt = 16'h0000;
      next_cur.pin_rst = 1'b0;
    end
    next_cur.port_val = shared_reset_port_pin;
    // checker helper only: consecutive qualified low samples
    if (reset_pin_disable || shared_reset_port_pin)
      next_cur.low_run = 16'h0000;
    else if (cur.low_run != 16'hffff)
      next_cur.low_run = cur.low_run + 16'h0001;
    case (cur.phase)
      ST_RESET:
      begin
        next_cur.warm_cnt = 16'h0000;
        if (!any_reset)
          next_cur.phase = ST_WARMUP;
      end
      ST_WARMUP:
      begin
        if (any_reset)
        begin
          next_cur.phase = ST_RESET;
          next_cur.warm_cnt = 16'h0000;
        end
        else if (cur.warm_cnt == 16'(WARMUP_LEN - 1))
          next_cur.phase = ST_RUN;
        else
          next_cur.warm_cnt = cur.warm_cnt + 16'h0001;
      end
      ST_RUN:
      begin
        if (any_reset)
          next_cur.phase = ST_RESET;
      end
      default:
        next_cur.phase = ST_RESET;
    endcase
    if (cause_clear_request_wr)
      next_cur.clr_req = cause_clear_request_wdata;
    if (reset_pin_disable_wr)
      next_cur.pin_dis_stage = reset_pin_disable_wdata;
    // other key values leave staged bits untouched
    if (key_wr && key_wdata == KEY_CAUSE_CLEAR && cur.clr_req)
    begin
      next_cur.cause = CAUSE_RESET;
      next_cur.trim_err = 1'b0;
      next_cur.clr_req = 1'b0;
    end
    // a bad load in the clearing cycle still sets the flag
    if (cur.phase == ST_WARMUP && !any_reset && trim_load_abnormal)
      next_cur.trim_err = 1'b1;
    if (key_wr && key_wdata == KEY_PIN_SWITCH)
      next_cur.pin_dis = cur.pin_dis_stage;
    // new events win over a clear in the same cycle
    next_cur.cause = next_cur.cause | factors;
    if (ext_reset)
    begin
      next_cur.cause = CAUSE_RESET;
      next_cur.trim_err = 1'b0;
      next_cur.clr_req = 1'b0;
    end
    if (por_below_threshold)
    begin
      next_cur.pin_dis = RST_PIN_DISABLE_RESET;
      next_cur.pin_dis_stage = RST_PIN_DISABLE_RESET;
    end
    next_cur.pin_fun = !next_cur.pin_dis;
    next_cur.sys_rst_out = (next_cur.phase == ST_RESET);
    next_cur.hold = (next_cur.phase != ST_RUN);
    next_cur.warm = (next_cur.phase == ST_WARMUP);
    next_cur.vec = RESET_VECTOR_ADDR;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cur.phase <= ST_RESET;
      cur.warm_cnt <= 16'h0000;
      cur.low_cnt <= 16'h0000;
      cur.pin_rst <= 1'b0;
      cur.sys_rst_out <= 1'b1;
      cur.hold <= 1'b1;
      cur.warm <= 1'b0;
      cur.cause <= CAUSE_RESET;
      cur.trim_err <= 1'b0;
      cur.clr_req <= 1'b0;
      cur.pin_dis_stage <= RST_PIN_DISABLE_RESET;
      cur.pin_dis <= RST_PIN_DISABLE_RESET;
      cur.pin_fun <= ~RST_PIN_DISABLE_RESET;
      cur.port_val <= 1'b1;
      cur.vec <= RESET_VECTOR_ADDR;
      cur.low_run <= 16'h0000;
    end
    else
      cur <= next_cur;
  end

  assign system_reset = cur.sys_rst_out;
  assign cpu_hold = cur.hold;
  assign warmup_active = cur.warm;
  assign trim_load_en = cur.warm;
  assign fetch_vector_addr = cur.vec;
  assign reset_cause_status = cur.cause;
  assign trim_data_error_flag = cur.trim_err;
  assign cause_clear_request = cur.clr_req;
  assign reset_pin_disable = cur.pin_dis;
  assign reset_pin_function = cur.pin_fun;
  assign port_pin_value = cur.port_val;

  a_por_holds_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    por_below_threshold |=> system_reset)
    else $error("power-on level did not hold reset");
  a_por_pin_restore: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    por_below_threshold |=> (!reset_pin_disable && reset_pin_function))
    else $error("pin not reset function after power-on");
  a_or_pin_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cur.pin_rst |=> (system_reset && cpu_hold))
    else $error("qualified pin reset did not hold the chip");
  a_warmup_after_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (cur.phase == ST_RESET && !any_reset) |=> warmup_active)
    else $error("warm-up did not start at release");

  a_hold_until_run: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    warmup_active |-> cpu_hold)
    else $error("cpu released during warm-up");
  a_reset_holds_cpu: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    system_reset |-> (cpu_hold && !warmup_active))
    else $error("cpu released or warm-up shown during reset");
  a_warm_count_bound: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    warmup_active |-> (cur.warm_cnt < 16'(WARMUP_LEN)))
    else $error("warm-up count beyond its length");
  a_run_after_warmup: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (warmup_active && !any_reset && cur.warm_cnt == 16'(WARMUP_LEN - 1))
    |=> !cpu_hold)
    else $error("cpu not released after warm-up");

  a_pin_low_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (cur.low_run >= 16'(PIN_LOW_CYCLES)) |-> cur.pin_rst)
    else $error("long pin low did not reset");
  a_short_low_ignored: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (cur.low_run < 16'(PIN_LOW_CYCLES)) |-> !cur.pin_rst)
    else $error("short pin low taken as reset");

  a_factor_resets: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (|factors) |=> (system_reset && cpu_hold))
    else $error("internal factor did not reset");
  a_volt_recorded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (volt_detect_event && !ext_reset) |=> reset_cause_status[CAUSE_VOLT])
    else $error("voltage cause not recorded");
  a_factor_recorded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (wdt_overflow && !ext_reset) |=> reset_cause_status[CAUSE_WDT])
    else $error("watchdog cause not recorded");
  a_clock_recorded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clock_deadlock && !ext_reset) |=> reset_cause_status[CAUSE_CLK])
    else $error("clock cause not recorded");
  a_trim_recorded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (trim_corrupt && !ext_reset) |=> reset_cause_status[CAUSE_TRIM])
    else $error("trim cause not recorded");
  a_flash_recorded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (flash_standby_access && !ext_reset)
    |=> reset_cause_status[CAUSE_FLASH])
    else $error("flash cause not recorded");

  a_trim_flag_set: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (warmup_active && !any_reset && trim_load_abnormal)
    |=> trim_data_error_flag)
    else $error("abnormal trim load not flagged");
  a_trim_load_start: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (system_reset && !any_reset) |=> trim_load_en)
    else $error("trim load not enabled at warm-up");

  a_ext_clears_cause: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ext_reset |=> (reset_cause_status == '0 && !trim_data_error_flag))
    else $error("pin or power-on reset left cause status");
  a_cause_sticky: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!ext_reset && !key_wr)
    |=> ((reset_cause_status & $past(reset_cause_status))
         == $past(reset_cause_status)))
    else $error("cause bit lost without clear");
  a_key_clears: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (key_wr && key_wdata == KEY_CAUSE_CLEAR && cause_clear_request
     && factors == '0)
    |=> (reset_cause_status == '0 && !cause_clear_request))
    else $error("keyed clear failed");
  a_clear_needs_request: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (key_wr && key_wdata == KEY_CAUSE_CLEAR && !cause_clear_request
     && !ext_reset)
    |=> ((reset_cause_status & $past(reset_cause_status))
         == $past(reset_cause_status)))
    else $error("cause cleared without request");
  a_bad_clear_key: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (key_wr && key_wdata != KEY_CAUSE_CLEAR && !ext_reset)
    |=> ((reset_cause_status & $past(reset_cause_status))
         == $past(reset_cause_status)
         && cause_clear_request == $past(cause_clear_request)))
    else $error("cause changed by wrong key");

  a_pin_disable_key: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (key_wr && key_wdata == KEY_PIN_SWITCH && !por_below_threshold)
    |=> (reset_pin_disable == $past(cur.pin_dis_stage)
         && reset_pin_function == !$past(cur.pin_dis_stage)))
    else $error("pin switch key not applied");
  a_port_no_reset: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    reset_pin_disable |=> !cur.pin_rst)
    else $error("port pin still resets");
  a_port_value_copy: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |=> (port_pin_value == $past(shared_reset_port_pin)))
    else $error("port value not a copy of the pin");
  a_bad_key_ignored: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (key_wr && key_wdata != KEY_PIN_SWITCH && !por_below_threshold)
    |=> $stable(reset_pin_disable))
    else $error("pin function changed without key");

  a_warm_restart: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (warmup_active && any_reset) |=> (system_reset && !warmup_active))
    else $error("reset during warm-up not restarted");
  a_warm_count_fresh: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (system_reset && !any_reset) |=> (cur.warm_cnt == 16'h0000))
    else $error("warm-up did not start from zero");
  a_vector_constant: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !cpu_hold |-> (fetch_vector_addr == RESET_VECTOR_ADDR))
    else $error("wrong reset vector at run");

endmodule // reset_source_controller

// ---- verilog/reset_source_pkg.sv ----
// constants for the reset source controller
package reset_source_pkg;
  localparam logic [7:0] KEY_CAUSE_CLEAR = 8'h71;
  localparam logic [7:0] KEY_PIN_SWITCH = 8'hb2;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
  localparam int CLK_MHZ = 40;
  localparam int PIN_LOW_MIN_NS = 5000;
  localparam int PIN_LOW_CYCLES = (PIN_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WARMUP_CYCLES = 256;
  localparam int CAUSE_BITS = 5;
  localparam int CAUSE_VOLT = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_CLK = 2;
  localparam int CAUSE_TRIM = 3;
  localparam int CAUSE_FLASH = 4;
  localparam logic [CAUSE_BITS-1:0] CAUSE_RESET = 5'h00;
  localparam logic RST_PIN_DISABLE_RESET = 1'b0;
  typedef enum logic [1:0] {ST_RESET, ST_WARMUP, ST_RUN} phase_t;
endpackage
